// *** design/gob_defines.svh ***
`ifndef GOB_DEFINES_SVH
`define GOB_DEFINES_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define GOB_FIRST_OFFS 8'h0d
`define GOB_LAST_OFFS 8'h23
`define GOB_NUM_REGS 23
`define GOB_RED2_COARSE_OFFS 8'h0d
`define GOB_RED2_FINE_HIGH_OFFS 8'h0e
`define GOB_RED2_FINE_LOW_OFFS 8'h0f
`define GOB_GREEN1_GAIN_OFFS 8'h10
`define GOB_GREEN1_COARSE_OFFS 8'h11
`define GOB_GREEN1_FINE_HIGH_OFFS 8'h12
`define GOB_GREEN1_FINE_LOW_OFFS 8'h13
`define GOB_GREEN2_GAIN_OFFS 8'h14
`define GOB_GREEN2_COARSE_OFFS 8'h15
`define GOB_GREEN2_FINE_HIGH_OFFS 8'h16
`define GOB_GREEN2_FINE_LOW_OFFS 8'h17
`define GOB_BLUE1_GAIN_OFFS 8'h18
`define GOB_BLUE1_COARSE_OFFS 8'h19
`define GOB_BLUE1_FINE_HIGH_OFFS 8'h1a
`define GOB_BLUE1_FINE_LOW_OFFS 8'h1b
`define GOB_BLUE2_GAIN_OFFS 8'h1c
`define GOB_BLUE2_COARSE_OFFS 8'h1d
`define GOB_BLUE2_FINE_HIGH_OFFS 8'h1e
`define GOB_BLUE2_FINE_LOW_OFFS 8'h1f
`define GOB_RED_TARGET_OFFS 8'h20
`define GOB_GREEN_TARGET_OFFS 8'h21
`define GOB_BLUE_TARGET_OFFS 8'h22
`define GOB_LOOP_CTL_OFFS 8'h23
// channel group stride; red2 group starts at its (absent) gain slot
`define GOB_CHAN_BASE_OFFS 8'h0c
`define GOB_CHAN_STRIDE 4

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define GOB_GAIN_RST 8'h00
`define GOB_COARSE_RST 8'h10
`define GOB_FINE_HIGH_RST 8'h80
`define GOB_FINE_LOW_RST 8'h00
`define GOB_TARGET_RST 8'h20
`define GOB_LOOP_CTL_RST 8'h0c

// ------------------------------------------------------------------
// writable-bit masks and field positions
// ------------------------------------------------------------------
`define GOB_GAIN_MASK 8'hff
`define GOB_COARSE_MASK 8'h1f
`define GOB_FINE_HIGH_MASK 8'hff
`define GOB_FINE_LOW_MASK 8'he0
`define GOB_TARGET_MASK 8'h7f
`define GOB_LOOP_CTL_MASK 8'hdf
`define GOB_FINE_LOW_LSB 5
`define GOB_CTL_LINES_LSB 6
`define GOB_CTL_HS_DIV2_BIT 4
`define GOB_CTL_AUTO_PULSE_BIT 3
`define GOB_CTL_LOOP_EN_BIT 2
`define GOB_CTL_HS_EN_BIT 1
`define GOB_CTL_FINE_ONLY_BIT 0
`define GOB_LINES_16 7'h10
`define GOB_LINES_32 7'h20
`define GOB_LINES_64 7'h40

`endif

// *** design/gob_pkg.sv ***
package gob_pkg;

    typedef logic [7:0] byte_t;

    // one channel's analog codes
    typedef struct packed {
        logic [7:0] gain;
        logic [4:0] coarse;
        logic [10:0] fine;
    } chan_s;

    // black-level loop control fields
    typedef struct packed {
        logic [1:0] line_sel;
        logic hs_div2;
        logic auto_pulse;
        logic loop_en;
        logic hs_en;
        logic fine_only;
    } loop_ctl_s;

    typedef enum logic [1:0] {
        LINES_UNLIMITED = 2'h0,
        LINES_16 = 2'h1,
        LINES_32 = 2'h2,
        LINES_64 = 2'h3
    } line_sel_e;

endpackage : gob_pkg

// *** design/gain_offset_black_regs.sv ***
`timescale 1ns/1ps
`include "gob_defines.svh"
// Notes on behaviour
// (RQ1) gain registers hold 8-bit code; gain is 283/(283-code).
// (RQ2) gain spans unity to ten times; reset 0x00 means unity.
// (RQ3) coarse offset is 5-bit offset binary in [4:0], reset 0x10.
// (RQ4) fine offset 11 bits: [10:3] in one register, [2:0] in next [7:5].
// (RQ5) fine high byte resets 0x80, low bits register 0x00: mid-scale.
// (RQ6) per-colour black target, 7 bits in [6:0], resets 0x20.
// (RQ7) control [7:6] sets clamp lines: unlimited, 16, 32 or 64.
// (RQ8) control [4] picks high-speed integration: 1 halves, 0 four-thirds.
// (RQ9) control [3] enables automatic black clamp pulse generation.
// (RQ10) control [2] enables the automatic black-level loop.
// (RQ11) control [1] puts the loop into high-speed mode.
// (RQ12) control [0]: 1 adjusts fine only, 0 coarse and fine.
// (RQ13) control register resets 0x0C: pulse and loop on, lines unlimited.
// (RQ14) register reset command returns every register here to defaults.
// (RQ15) reserved bits read zero; writing them does nothing.
module gain_offset_black_regs (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // register reset command from the soft reset register
    input wire logic REG_RESET_CMD,
    // register port from the serial configuration interface
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WE,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT,
    // decoded settings for the analog channels and the loop
    output gob_pkg::chan_s [4:0] CHAN_CFG,
    output logic [2:0][6:0] BLACK_TARGET,
    output gob_pkg::loop_ctl_s LOOP_CTL,
    output logic LINES_UNLIMITED,
    output logic [6:0] LINE_LIMIT
);

    // ------------------------------------------------------------------
    // per-offset tables
    // ------------------------------------------------------------------
    function automatic gob_pkg::byte_t rst_val(input logic [7:0] a);
        gob_pkg::byte_t v;
        v = `GOB_FINE_LOW_RST;
        if (a == `GOB_LOOP_CTL_OFFS) begin
            v = `GOB_LOOP_CTL_RST; // RQ13
        end else if (a >= `GOB_RED_TARGET_OFFS) begin
            v = `GOB_TARGET_RST; // RQ6
        end else begin
            case (a[1:0])
                2'h0: v = `GOB_GAIN_RST; // RQ2
                2'h1: v = `GOB_COARSE_RST; // RQ3
                2'h2: v = `GOB_FINE_HIGH_RST; // RQ5
                default: v = `GOB_FINE_LOW_RST; // RQ5
            endcase
        end
        return v;
    endfunction : rst_val

    function automatic gob_pkg::byte_t wr_mask(input logic [7:0] a);
        gob_pkg::byte_t m;
        m = `GOB_FINE_LOW_MASK;
        if (a == `GOB_LOOP_CTL_OFFS) begin
            m = `GOB_LOOP_CTL_MASK; // RQ15
        end else if (a >= `GOB_RED_TARGET_OFFS) begin
            m = `GOB_TARGET_MASK; // RQ15
        end else begin
            case (a[1:0])
                2'h0: m = `GOB_GAIN_MASK;
                2'h1: m = `GOB_COARSE_MASK; // RQ15
                2'h2: m = `GOB_FINE_HIGH_MASK;
                default: m = `GOB_FINE_LOW_MASK; // RQ15
            endcase
        end
        return m;
    endfunction : wr_mask

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    gob_pkg::byte_t regs_q [`GOB_NUM_REGS];
    gob_pkg::byte_t regs_d [`GOB_NUM_REGS];

    genvar gi;
    generate
        for (gi = 0; gi < `GOB_NUM_REGS; gi++) begin : g_reg
            localparam logic [7:0] OFFS = 8'(`GOB_FIRST_OFFS + gi);
            localparam gob_pkg::byte_t RST = rst_val(OFFS);
            localparam gob_pkg::byte_t MASK = wr_mask(OFFS);

            // reset command beats a write in the same cycle
            always_comb begin
                if (REG_RESET_CMD) begin
                    regs_d[gi] = RST; // RQ14
                end else if (REG_WE && REG_ADDR == OFFS) begin
                    regs_d[gi] = REG_WDATA & MASK; // RQ15
                end else begin
                    regs_d[gi] = regs_q[gi];
                end
            end

            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    regs_q[gi] <= RST;
                end else begin
                    regs_q[gi] <= regs_d[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic hit_d;
    logic hit_q;
    logic [7:0] rd_idx;

    // stored values are already masked, so reserved bits read zero
    always_comb begin
        rd_idx = REG_ADDR - `GOB_FIRST_OFFS;
        rdata_d = 8'h00;
        hit_d = 1'b0;
        if (REG_ADDR >= `GOB_FIRST_OFFS && REG_ADDR <= `GOB_LAST_OFFS) begin
            rdata_d = regs_q[rd_idx[4:0]]; // RQ15
            hit_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_HIT = hit_q;

    // ------------------------------------------------------------------
    // channel codes
    // ------------------------------------------------------------------
    generate
        for (gi = 0; gi < 5; gi++) begin : g_chan
            localparam int BASE = `GOB_CHAN_STRIDE * gi + 32'(`GOB_CHAN_BASE_OFFS)
                - 32'(`GOB_FIRST_OFFS);
            // red2 gain lives outside this bank; its slot reads unity code
            if (gi == 0) begin : g_nogain
                assign CHAN_CFG[gi].gain = `GOB_GAIN_RST;
            end else begin : g_gain
                assign CHAN_CFG[gi].gain = regs_q[BASE]; // RQ1
            end
            assign CHAN_CFG[gi].coarse = regs_q[BASE + 1][4:0]; // RQ3
            assign CHAN_CFG[gi].fine = {regs_q[BASE + 2],
                regs_q[BASE + 3][7:`GOB_FINE_LOW_LSB]}; // RQ4
        end
        for (gi = 0; gi < 3; gi++) begin : g_target
            assign BLACK_TARGET[gi] = regs_q[32'(`GOB_RED_TARGET_OFFS) + gi
                - 32'(`GOB_FIRST_OFFS)][6:0]; // RQ6
        end
    endgenerate

    // ------------------------------------------------------------------
    // loop control
    // ------------------------------------------------------------------
    gob_pkg::byte_t ctl;
    gob_pkg::line_sel_e line_sel;

    assign ctl = regs_q[`GOB_NUM_REGS - 1];
    assign line_sel = gob_pkg::line_sel_e'(ctl[`GOB_CTL_LINES_LSB +: 2]);
    assign LOOP_CTL.line_sel = ctl[`GOB_CTL_LINES_LSB +: 2];
    assign LOOP_CTL.hs_div2 = ctl[`GOB_CTL_HS_DIV2_BIT]; // RQ8
    assign LOOP_CTL.auto_pulse = ctl[`GOB_CTL_AUTO_PULSE_BIT]; // RQ9
    assign LOOP_CTL.loop_en = ctl[`GOB_CTL_LOOP_EN_BIT]; // RQ10
    assign LOOP_CTL.hs_en = ctl[`GOB_CTL_HS_EN_BIT]; // RQ11
    assign LOOP_CTL.fine_only = ctl[`GOB_CTL_FINE_ONLY_BIT]; // RQ12

    always_comb begin
        LINES_UNLIMITED = 1'b0;
        case (line_sel)
            gob_pkg::LINES_16: LINE_LIMIT = `GOB_LINES_16; // RQ7
            gob_pkg::LINES_32: LINE_LIMIT = `GOB_LINES_32; // RQ7
            gob_pkg::LINES_64: LINE_LIMIT = `GOB_LINES_64; // RQ7
            default: begin
                LINE_LIMIT = 7'h00;
                LINES_UNLIMITED = 1'b1; // RQ7
            end
        endcase
    end

endmodule : gain_offset_black_regs

// *** verif/gob_asserts.sv ***
`timescale 1ns/1ps
module gob_asserts (
    // clock, reset
    input wire logic CLK,
    input wire logic RST_B,
    // register port
    input wire logic REG_RESET_CMD,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WE,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_HIT,
    // decoded settings
    input wire gob_pkg::chan_s [4:0] CHAN_CFG,
    input wire logic [2:0][6:0] BLACK_TARGET,
    input wire gob_pkg::loop_ctl_s LOOP_CTL,
    input wire logic LINES_UNLIMITED,
    input wire logic [6:0] LINE_LIMIT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    // a write the bank takes
    sequence s_wr(a);
        REG_WE && !REG_RESET_CMD && REG_ADDR == a;
    endsequence
    property p_unmapped;
        !(REG_ADDR inside {[8'h0d:8'h23]}) |=> REG_RDATA == 8'h00 && !REG_HIT;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_gain;
        s_wr(8'h10) |=> CHAN_CFG[1].gain == $past(REG_WDATA);
    endproperty
    a_gain: assert property (p_gain) else $error("gain");
    property p_coarse;
        s_wr(8'h19) |=> CHAN_CFG[3].coarse == $past(REG_WDATA[4:0]);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse");
    property p_fine_hi;
        s_wr(8'h1e) |=> CHAN_CFG[4].fine[10:3] == $past(REG_WDATA);
    endproperty
    a_fine_hi: assert property (p_fine_hi) else $error("fine high");
    property p_fine_lo;
        s_wr(8'h0f) |=> CHAN_CFG[0].fine[2:0] == $past(REG_WDATA[7:5]);
    endproperty
    a_fine_lo: assert property (p_fine_lo) else $error("fine low");
    property p_ctl;
        s_wr(8'h23) |=> LOOP_CTL == {$past(REG_WDATA[7:6]), $past(REG_WDATA[4:0])};
    endproperty
    a_ctl: assert property (p_ctl) else $error("loop control");
    // line limit is a pure decode of the line selection
    property p_lines;
        LINES_UNLIMITED == (LOOP_CTL.line_sel == 2'h0) && LINE_LIMIT ==
            (LOOP_CTL.line_sel == 2'h0 ? 7'h00 : 7'h08 << LOOP_CTL.line_sel);
    endproperty
    a_lines: assert property (p_lines) else $error("line limit");
    property p_cmd;
        REG_RESET_CMD |=> LOOP_CTL == 7'h0c && BLACK_TARGET[0] == 7'h20 &&
            CHAN_CFG[2] == {8'h00, 5'h10, 11'h400};
    endproperty
    a_cmd: assert property (p_cmd) else $error("reset command");
    property p_target;
        s_wr(8'h22) |=> BLACK_TARGET[2] == $past(REG_WDATA[6:0]);
    endproperty
    a_target: assert property (p_target) else $error("black target");
    property p_auto_pulse;
        s_wr(8'h23) |=> LOOP_CTL.auto_pulse == $past(REG_WDATA[3]);
    endproperty
    a_auto_pulse: assert property (p_auto_pulse) else $error("auto pulse");
    property p_loop_en;
        s_wr(8'h23) |=> LOOP_CTL.loop_en == $past(REG_WDATA[2]);
    endproperty
    a_loop_en: assert property (p_loop_en) else $error("loop enable");
    property p_hs_en;
        s_wr(8'h23) |=> LOOP_CTL.hs_en == $past(REG_WDATA[1]);
    endproperty
    a_hs_en: assert property (p_hs_en) else $error("high speed enable");
    property p_fine_only;
        s_wr(8'h23) |=> LOOP_CTL.fine_only == $past(REG_WDATA[0]);
    endproperty
    a_fine_only: assert property (p_fine_only) else $error("fine only");
    // gains written at random earlier must fall back to the unity code
    property p_cmd_gain;
        REG_RESET_CMD |=> CHAN_CFG[1].gain == 8'h00 && CHAN_CFG[3].gain == 8'h00;
    endproperty
    a_cmd_gain: assert property (p_cmd_gain) else $error("gain default");
    property p_cmd_ctl;
        REG_RESET_CMD |=> LOOP_CTL.auto_pulse && LOOP_CTL.loop_en && LINES_UNLIMITED;
    endproperty
    a_cmd_ctl: assert property (p_cmd_ctl) else $error("control default");
endmodule : gob_asserts
bind gain_offset_black_regs gob_asserts i_gob_asserts (
    .CLK(CLK),
    .RST_B(RST_B),
    .REG_RESET_CMD(REG_RESET_CMD),
    .REG_ADDR(REG_ADDR),
    .REG_WE(REG_WE),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .REG_HIT(REG_HIT),
    .CHAN_CFG(CHAN_CFG),
    .BLACK_TARGET(BLACK_TARGET),
    .LOOP_CTL(LOOP_CTL),
    .LINES_UNLIMITED(LINES_UNLIMITED),
    .LINE_LIMIT(LINE_LIMIT)
);

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    output logic reg_reset_cmd,
    output logic [7:0] reg_addr,
    output logic reg_we,
    output logic [7:0] reg_wdata,
    // read presented
    output logic rd_mark
);
    initial begin
        {reg_reset_cmd, reg_addr, reg_we, reg_wdata, rd_mark} = '0;
    end
    // one request a cycle; values change only after an edge
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w,
                       input logic c, input logic r);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= w;
        reg_reset_cmd <= c;
        rd_mark <= r;
    endtask : put
endmodule : host_model

// *** verif/gain_offset_black_regs_bench.sv ***
`timescale 1ns/1ps
module gain_offset_black_regs_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd, we, mark, hit;
    logic [7:0] addr, wdata, rdata;
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'hc2340731;
    logic [7:0] img [256];
    logic [16:0] notes [$];
    int n_mismatch = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    host_model i_host_model (.clk(clk), .reg_reset_cmd(cmd), .reg_addr(addr),
        .reg_we(we), .reg_wdata(wdata), .rd_mark(mark));
    gain_offset_black_regs i_gain_offset_black_regs (.CLK(clk), .RST_B(rst_b),
        .REG_RESET_CMD(cmd), .REG_ADDR(addr), .REG_WE(we), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_HIT(hit), .CHAN_CFG(), .BLACK_TARGET(),
        .LOOP_CTL(), .LINES_UNLIMITED(), .LINE_LIMIT());
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] mask(input logic [7:0] a);
        if (a == 8'h23) return 8'hdf;
        if (a >= 8'h20) return 8'h7f;
        return a[1:0] == 2'h1 ? 8'h1f : (a[1:0] == 2'h3 ? 8'he0 : 8'hff);
    endfunction : mask
    // defaults of the whole bank, also after a reset command
    task automatic restore();
        img = '{default: 8'h00};
        for (int a = 8'h0d; a <= 8'h20; a++) begin
            img[a] = a[1:0] == 2'h1 ? 8'h10 : (a[1:0] == 2'h2 ? 8'h80 : 8'h00);
        end
        img[8'h20] = 8'h20;
        img[8'h21] = 8'h20;
        img[8'h22] = 8'h20;
        img[8'h23] = 8'h0c;
    endtask : restore
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c);
        i_host_model.put(a, d, 1'b1, c, 1'b0);
        if (c) begin
            restore();
        end else if (a inside {[8'h0d:8'h23]}) begin
            img[a] = d & mask(a);
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        seed = lfsr(seed);
        notes.push_back({a, a inside {[8'h0d:8'h23]}, img[a]});
        i_host_model.put(a, seed[7:0], 1'b0, 1'b0, 1'b1);
    endtask : rd
    task automatic read_all(input int t);
        for (int a = 8'h0b; a <= 8'h25; a++) begin
            rd(a[7:0]);
        end
        $display("test %0d done", t);
    endtask : read_all
    task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // answer comes one edge after the address is taken
    always @(posedge clk) begin
        rd_seen <= mark;
        if (rd_seen && notes.size() > 0) begin
            logic [16:0] n;
            n = notes.pop_front();
            chk($sformatf("reg %h", n[16:9]), {hit, rdata}, n[8:0]);
        end
    end
    initial begin
        restore();
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        read_all(1);
        for (int a = 8'h0b; a <= 8'h25; a++) begin
            seed = lfsr(seed);
            wr(a[7:0], seed[7:0], 1'b0);
            rd(a[7:0]);
        end
        read_all(2);
        for (int k = 0; k < 4; k++) begin
            wr(8'h23, {k[1:0], 6'h3f}, 1'b0);
            wr(8'h23, {k[1:0], 6'h00}, 1'b0);
            rd(8'h23);
        end
        // command must win over the write in the same cycle
        wr(8'h10, 8'h5a, 1'b1);
        read_all(3);
        i_host_model.put(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        finish_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : gain_offset_black_regs_bench
